// ---- uem_top.sv ----
/*
 endpoint interrupt masking: fifo-empty masks, ep1 dedicated irq and event masks.
 assumes event pulses arrive on clk from the endpoint logic and one-cycle register strobes.
*/
// Chosen here: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module uem_top #(
   parameter int EPS = 16
) (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire uem_pkg::uem_req_s    req,
   output logic [31:0]               rdata,
   input  wire uem_pkg::uem_events_s events,
   output logic [EPS-1:0]            fifo_empty_irq,
   output logic                      in_ep1_irq,
   output logic                      out_ep1_irq,
   output logic                      irq
);

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [31:0] fifo_mask_q;
   logic [31:0] ep1_mask_q;
   logic [31:0] in_mask_q;
   logic [31:0] out_mask_q;
   logic [31:0] in_stat_q;
   logic [31:0] out_stat_q;
   logic [EPS-1:0] fifo_stat_q;
   logic [1:0]  irq_stat_q;
   logic [1:0]  irq_mask_q;
   logic        in_req;
   logic        out_req;
   logic [31:0] ep1_irq;
   logic [31:0] rdata_d;
   logic        wr_in_stat;
   logic        wr_irq_stat;

   assign wr_in_stat  = req.wr && req.addr == uem_pkg::OFS_EP1_EVENT_STATUS;
   assign wr_irq_stat = req.wr && req.addr == uem_pkg::OFS_IRQ_STATUS;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fifo_mask_q <= uem_pkg::RST_VALUE;
         ep1_mask_q  <= uem_pkg::RST_VALUE;
         in_mask_q   <= uem_pkg::RST_VALUE;
         out_mask_q  <= uem_pkg::RST_VALUE;
         irq_mask_q  <= 2'h0;
      end else if (req.wr) begin
         if (req.addr == uem_pkg::OFS_IN_FIFO_EMPTY_IRQ_MASK) begin
            fifo_mask_q <= req.wdata & uem_pkg::WMASK_FIFO_EMPTY;
         end
         if (req.addr == uem_pkg::OFS_EP1_DEDICATED_IRQ_MASK) begin
            ep1_mask_q <= req.wdata & uem_pkg::WMASK_EP1_IRQ;
         end
         if (req.addr == uem_pkg::OFS_IN_EP1_EVENT_MASK) begin
            in_mask_q <= req.wdata & uem_pkg::WMASK_IN_EP1;
         end
         if (req.addr == uem_pkg::OFS_OUT_EP1_EVENT_MASK) begin
            out_mask_q <= req.wdata & uem_pkg::WMASK_OUT_EP1;
         end
         if (req.addr == uem_pkg::OFS_IRQ_MASK) begin
            irq_mask_q <= req.wdata[1:0] & uem_pkg::WMASK_IRQ;
         end
      end
   end

   // ---------------------------------------------------------------
   // event status, write one to clear, set wins
   // ---------------------------------------------------------------
   // record even when masked
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         in_stat_q  <= uem_pkg::RST_VALUE;
         out_stat_q <= uem_pkg::RST_VALUE;
      end else begin
         in_stat_q  <= (in_stat_q & ~(wr_in_stat ? req.wdata : 32'h0000_0000))
                       | (events.in_ep1 & uem_pkg::WMASK_IN_EP1);
         out_stat_q <= (out_stat_q & ~(wr_in_stat ? {16'h0000, req.wdata[31:16]} : 32'h0000_0000))
                       | (events.out_ep1 & uem_pkg::WMASK_OUT_EP1);
      end
   end

   // fifo-empty is a level from the tx fifo, so it simply follows it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fifo_stat_q <= '0;
      end else begin
         fifo_stat_q <= events.fifo_empty[EPS-1:0];
      end
   end

   // ---------------------------------------------------------------
   // request forming
   // ---------------------------------------------------------------
   uem_gate #(.W(32)) u_in_gate (
      .status (in_stat_q),
      .mask   (in_mask_q),
      .req    (in_req)
   );

   uem_gate #(.W(32)) u_out_gate (
      .status (out_stat_q),
      .mask   (out_mask_q),
      .req    (out_req)
   );

   always_comb begin
      ep1_irq = 32'h0000_0000;
      ep1_irq[uem_pkg::BIT_OUT_EP1_IRQ] = out_req;
      ep1_irq[uem_pkg::BIT_IN_EP1_IRQ]  = in_req;
   end

   genvar g;
   generate
      for (g = 0; g < EPS; g++) begin : g_fe
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               fifo_empty_irq[g] <= 1'b0;
            end else begin
               fifo_empty_irq[g] <= fifo_stat_q[g] & fifo_mask_q[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         in_ep1_irq  <= 1'b0;
         out_ep1_irq <= 1'b0;
      end else begin
         in_ep1_irq  <= in_req & ep1_mask_q[uem_pkg::BIT_IN_EP1_IRQ];
         out_ep1_irq <= out_req & ep1_mask_q[uem_pkg::BIT_OUT_EP1_IRQ];
      end
   end

   // ---------------------------------------------------------------
   // sticky summary interrupt
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_stat_q <= 2'h0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~(wr_irq_stat ? req.wdata[1:0] : 2'h0))
                       | {out_req & ep1_mask_q[uem_pkg::BIT_OUT_EP1_IRQ],
                          in_req & ep1_mask_q[uem_pkg::BIT_IN_EP1_IRQ]};
      end
   end

   // level irq registered so the output is a flop
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_q & irq_mask_q);
      end
   end

   // ---------------------------------------------------------------
   // read port
   // ---------------------------------------------------------------
   always_comb begin
      rdata_d = 32'h0000_0000;
      unique case (req.addr)
         uem_pkg::OFS_IN_FIFO_EMPTY_IRQ_MASK: rdata_d = fifo_mask_q;
         uem_pkg::OFS_EP1_DEDICATED_IRQ:      rdata_d = ep1_irq;
         uem_pkg::OFS_EP1_DEDICATED_IRQ_MASK: rdata_d = ep1_mask_q;
         uem_pkg::OFS_IN_EP1_EVENT_MASK:      rdata_d = in_mask_q;
         uem_pkg::OFS_OUT_EP1_EVENT_MASK:     rdata_d = out_mask_q;
         uem_pkg::OFS_EP1_EVENT_STATUS:       rdata_d = {out_stat_q[15:0], in_stat_q[15:0]};
         uem_pkg::OFS_IRQ_STATUS:             rdata_d = {30'h0000_0000, irq_stat_q};
         uem_pkg::OFS_IRQ_MASK:               rdata_d = {30'h0000_0000, irq_mask_q};
         default:                             rdata_d = 32'h0000_0000;
      endcase
   end

   // unmapped or idle reads give zero; data held only one cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= 32'h0000_0000;
      end else begin
         rdata <= req.rd ? rdata_d : 32'h0000_0000;
      end
   end

endmodule
`default_nettype wire

// ---- uem_pkg.sv ----
/*
 endpoint interrupt mask block: register offsets, field positions, reset values, carriers.
 assumes a plain one-cycle register port on a single 200 MHz clock.
*/
package uem_pkg;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [11:0] OFS_IN_FIFO_EMPTY_IRQ_MASK = 12'h834;
   localparam logic [11:0] OFS_EP1_DEDICATED_IRQ      = 12'h838;
   localparam logic [11:0] OFS_EP1_DEDICATED_IRQ_MASK = 12'h83C;
   localparam logic [11:0] OFS_IN_EP1_EVENT_MASK      = 12'h840;
   localparam logic [11:0] OFS_OUT_EP1_EVENT_MASK     = 12'h880;
   localparam logic [11:0] OFS_EP1_EVENT_STATUS       = 12'h884;
   localparam logic [11:0] OFS_IRQ_STATUS             = 12'h888;
   localparam logic [11:0] OFS_IRQ_MASK               = 12'h88C;

   localparam logic [31:0] RST_VALUE = 32'h0000_0000;

   // ---------------------------------------------------------------
   // field positions and writable bits
   // ---------------------------------------------------------------
   localparam int BIT_OUT_EP1_IRQ = 17;
   localparam int BIT_IN_EP1_IRQ  = 1;
   localparam logic [31:0] WMASK_FIFO_EMPTY = 32'h0000_FFFF;
   localparam logic [31:0] WMASK_EP1_IRQ    = 32'h0002_0002;
   localparam logic [31:0] WMASK_IN_EP1     = 32'h0000_237B;
   localparam logic [31:0] WMASK_OUT_EP1    = 32'h0000_7307;
   localparam logic [1:0]  WMASK_IRQ        = 2'h3;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } uem_req_s;

   typedef struct packed {
      logic [15:0] fifo_empty;
      logic [31:0] in_ep1;
      logic [31:0] out_ep1;
   } uem_events_s;

endpackage

// ---- uem_gate.sv ----
/*
 and-or reduction of recorded events against their masks.
 assumes status and mask share one bit layout.
*/
`timescale 1ns/10ps
`default_nettype none
module uem_gate #(
   parameter int W = 32
) (
   input  wire logic [W-1:0] status,
   input  wire logic [W-1:0] mask,
   output logic              req
);
   assign req = |(status & mask);
endmodule
`default_nettype wire

// ---- uem_properties.sv ----
/* port checks for uem_top.
   assumes bind into uem_top, one clock. */
`timescale 1ns/10ps
`default_nettype none
module uem_props #(
   parameter int EPS = 16
) (
   input wire logic                 clk,
   input wire logic                 rst,
   input wire uem_pkg::uem_req_s    req,
   input wire logic [31:0]          rdata,
   input wire uem_pkg::uem_events_s events,
   input wire logic [EPS-1:0]       fifo_empty_irq,
   input wire logic                 in_ep1_irq,
   input wire logic                 out_ep1_irq,
   input wire logic                 irq
);
   // -----------------------------------------
   // assertions
   // -----------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property resv_low(logic [11:0] a, logic [31:0] m);
      $past(req.rd) && $past(req.addr) == a |-> (rdata & ~m) == 32'h0;
   endproperty
   chk_rdata_idle: assert property (!$past(req.rd) |-> rdata == 32'h0)
      else $error("rdata outside read");
   chk_fifo_resv: assert property (resv_low(12'h834, uem_pkg::WMASK_FIFO_EMPTY))
      else $error("fifo mask reserved");
   chk_ep1_resv: assert property (resv_low(12'h838, uem_pkg::WMASK_EP1_IRQ))
      else $error("ep1 irq reserved");
   chk_in_resv: assert property (resv_low(12'h840, uem_pkg::WMASK_IN_EP1))
      else $error("in mask reserved");
   chk_out_resv: assert property (resv_low(12'h880, uem_pkg::WMASK_OUT_EP1))
      else $error("out mask reserved");
   chk_fifo_gate: assert property ((fifo_empty_irq & ~EPS'($past(events.fifo_empty, 2))) == '0)
      else $error("fifo irq without event");
   // levels only drop after software acts
   // a write lands on the strobe edge, the output flop drops one edge later
   chk_in_release: assert property ($fell(in_ep1_irq) |-> $past(req.wr, 2))
      else $error("in irq dropped alone");
   chk_out_release: assert property ($fell(out_ep1_irq) |-> $past(req.wr, 2))
      else $error("out irq dropped alone");
   chk_irq_release: assert property ($fell(irq) |-> $past(req.wr, 2))
      else $error("irq dropped alone");
   cover property (in_ep1_irq && irq);
   cover property ($fell(out_ep1_irq));
   cover property (fifo_empty_irq[EPS-1]);
endmodule
`default_nettype wire

// ---- uem_top_tb.sv ----
/* bench for uem_top: register table, gating, ep1 interrupts, reset.
   assumes uem_props bound below. */
`timescale 1ns/10ps
`default_nettype none
module uem_top_tb;
   logic                 clk, rst, in_irq, out_irq, irq;
   uem_pkg::uem_req_s    req;
   uem_pkg::uem_events_s ev;
   logic [31:0]          rdata;
   logic [15:0]          fe_irq;
   int                   failures, n_compared;
   logic [43:0]          rows [6] = '{{12'h834, 32'hFFFF}, {12'h838, 32'h0}, {12'h83C, 32'h20002},
                                      {12'h840, 32'h237B}, {12'h880, 32'h7307}, {12'h900, 32'h0}};
   uem_top #(.EPS(16)) DUT (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .events(ev),
      .fifo_empty_irq(fe_irq), .in_ep1_irq(in_irq), .out_ep1_irq(out_irq), .irq(irq));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // -----------------------------------------
   // bus and check tasks
   // -----------------------------------------
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(logic [11:0] a, logic [31:0] d);
      @(posedge clk) req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk) req <= '0;
   endtask
   task automatic rd(logic [11:0] a, logic [31:0] e);
      @(posedge clk) req <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge clk) req <= '0;
      #1 chk("rdata", rdata, e);
   endtask
   task automatic settle(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic pulse(logic [31:0] i, logic [31:0] o);
      @(posedge clk) ev <= '{16'hFFFF, i, o};
      @(posedge clk) ev <= '{16'hFFFF, 32'h0, 32'h0};
      settle(3);
   endtask
   task automatic conclude();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge clk);
      failures++;
      conclude();
   end
   initial begin
      rst = 1'b1;
      req = '0;
      ev = '{16'hFFFF, 32'h0, 32'h0};
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[k]) rd(rows[k][43:32], 32'h0);
      foreach (rows[k]) begin
         wr(rows[k][43:32], rows[k][31:0]);
         rd(rows[k][43:32], rows[k][31:0]);
      end
      $display("test registers done");
      for (int n = 0; n < 16; n++) begin
         wr(12'h834, 32'h1 << n);
         settle(2);
         chk("fifo_irq", {16'h0, fe_irq}, 32'h1 << n);
      end
      wr(12'h834, 32'hFFFF);
      @(posedge clk) ev <= '{16'h00F0, 32'h0, 32'h0};
      settle(3);
      chk("fifo_irq", {16'h0, fe_irq}, 32'h00F0);
      @(posedge clk) ev <= '{16'hFFFF, 32'h0, 32'h0};
      $display("test fifo gating done");
      wr(12'h840, 32'h1);
      wr(12'h88C, 32'h3);
      pulse(32'h2, 32'h0);
      chk("in_irq", {31'h0, in_irq}, 32'h0);
      rd(12'h884, 32'h2);
      pulse(32'h1, 32'h0);
      chk("in_irq irq", {30'h0, in_irq, irq}, 32'h3);
      rd(12'h838, 32'h2);
      wr(12'h884, 32'h3);
      wr(12'h888, 32'h3);
      settle(2);
      chk("in_irq irq", {30'h0, in_irq, irq}, 32'h0);
      $display("test in ep1 done");
      wr(12'h880, 32'h4000);
      pulse(32'h0, 32'h4000);
      chk("out_irq irq", {30'h0, out_irq, irq}, 32'h3);
      rd(12'h884, 32'h4000_0000);
      wr(12'h83C, 32'h2);
      settle(2);
      chk("out_irq", {31'h0, out_irq}, 32'h0);
      rd(12'h838, 32'h2_0000);
      wr(12'h884, 32'h4000_0000);
      rd(12'h884, 32'h0);
      rd(12'h838, 32'h0);
      $display("test out ep1 done");
      @(posedge clk) rst <= 1'b1;
      @(posedge clk) rst <= 1'b0;
      settle(1);
      chk("irqs", {29'h0, in_irq, out_irq, irq}, 32'h0);
      foreach (rows[k]) rd(rows[k][43:32], 32'h0);
      $display("test mid reset done");
      conclude();
   end
endmodule
bind uem_top uem_props #(.EPS(EPS)) u_props (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
   .events(events), .fifo_empty_irq(fifo_empty_irq), .in_ep1_irq(in_ep1_irq),
   .out_ep1_irq(out_ep1_irq), .irq(irq));
`default_nettype wire
